// [hdl/ttr_top.v]
// trace trigger unit: trigger vs interrupt priority, reset response, trace store
//
// Contract
// - with the timing select set, a target reaching the top of the pipe together with a pending interrupt is not a trigger.
// - with the timing select clear in an end run, a fetch of the target triggers even if an interrupt becomes pending then.
// - in that clear-select end case the core takes the vector and must halt before the first service instruction runs.
// - in that clear-select end case the arm bit is cleared and the interrupt change of flow is not stored.
// - with the timing select clear in a begin run, a trigger beside an interrupt stores that change of flow and stays armed.
// - the unit never asks for a reset of the microcontroller.
// - a reset after an end-run setup clears arm, armed flag and break enable and keeps the other bits.
// - every other reset, power-on included, sets up a begin run that fires on the reset vector fetch.
// - that default loads comparator A with extension 0x00, high 0xFF and low 0xFE.
// - that default loads the main control register with 0xC0.
// - that default loads the trigger control register with 0x40.
// - after a begin trigger the unit stays armed until eight change-of-flow words are stored.
// - an end-run trigger clears arm and armed flag and stops further storing.
`timescale 1ns/1ps
`include "ttr_defs.vh"

module ttr_top #(
  parameter DEPTH = `TTR_FIFO_DEPTH
) (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        clk_en,
  input  wire        por,
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_ff,
  input  wire [15:0] core_addr,
  input  wire        core_fetch,
  input  wire        core_top,
  input  wire        core_irq_pend,
  input  wire [1:0]  core_cof,
  output reg         brk_req_ff,
  output reg         mcu_rst_req_ff,
  output reg         armed_ff
);

  reg  [7:0]  ctrl_ff;
  reg  [7:0]  trig_ff;
  reg         armed_status_flag_ff;
  reg  [7:0]  cax_ff;
  reg  [7:0]  cah_ff;
  reg  [7:0]  cal_ff;
  reg  [3:0]  cnt_ff;
  reg  [2:0]  wptr_ff;
  reg  [2:0]  rptr_ff;
  reg         begun_ff;
  reg  [15:0] prev_addr_ff;
  reg  [15:0] fifo_mem [0:DEPTH-1];

  wire        en_bit    = ctrl_ff[`TTR_CTRL_EN];
  wire        arm_bit   = ctrl_ff[`TTR_CTRL_ARM];
  wire        breakpoint_request_enable_bit = ctrl_ff[`TTR_CTRL_BREAKPOINT_REQUEST_ENABLE];
  wire        sel_bit   = trig_ff[`TTR_TRIG_SEL];
  wire        begin_bit = trig_ff[`TTR_TRIG_BEGIN];
  wire        armed     = en_bit & arm_bit & armed_status_flag_ff;
  wire        addr_hit  = (cax_ff == 8'h00) & (core_addr == {cah_ff, cal_ff});

  // set select: decided at the top of the pipe, interrupt wins
  // clear select: decided on the fetch, interrupt does not veto
  wire        trig_hit  = armed & addr_hit &
                          (sel_bit ? (core_top & ~core_irq_pend) : core_fetch);

  wire        irq_case  = trig_hit & ~sel_bit & core_irq_pend;
  wire        cof_any   = |core_cof;
  wire [15:0] cof_addr  = core_cof[1] ? core_addr : (prev_addr_ff - `TTR_COF_STEP);
  wire        fifo_full = (cnt_ff == DEPTH[3:0]);

  // begin run: store only after the trigger, including the trigger cycle
  // end run: store up to the trigger; the interrupt flow is dropped
  wire        store_beg = armed & begin_bit & (begun_ff | trig_hit) & cof_any;
  wire        store_end = armed & ~begin_bit & cof_any & ~irq_case;
  wire        store     = store_beg | store_end;

  wire        beg_done  = store_beg & (cnt_ff == DEPTH[3:0] - 4'h1);
  wire        end_done  = trig_hit & ~begin_bit;

  wire        wr_ctrl   = reg_wr & (reg_addr == `TTR_OFS_CTRL);
  wire        wr_trig   = reg_wr & (reg_addr == `TTR_OFS_TRIG);
  wire        rd_low    = reg_rd & (reg_addr == `TTR_OFS_FL);
  wire [2:0]  oldest    = (cnt_ff == DEPTH[3:0]) ? wptr_ff : 3'h0;
  wire [2:0]  rd_idx    = armed ? oldest : rptr_ff;
  wire [15:0] rd_word   = fifo_mem[rd_idx];
  wire        retain    = ~por & en_bit & ~begin_bit;

  reg  [7:0]  nxt_rdata;

  always @*
  begin
    case (reg_addr)
      `TTR_OFS_CTRL: nxt_rdata = ctrl_ff;
      `TTR_OFS_TRIG: nxt_rdata = trig_ff;
      `TTR_OFS_STAT: nxt_rdata = {7'h00, armed_status_flag_ff};
      `TTR_OFS_CAX:  nxt_rdata = cax_ff;
      `TTR_OFS_CAH:  nxt_rdata = cah_ff;
      `TTR_OFS_CAL:  nxt_rdata = cal_ff;
      `TTR_OFS_FH:   nxt_rdata = rd_word[15:8];
      `TTR_OFS_FL:   nxt_rdata = rd_word[7:0];
      `TTR_OFS_CNT:  nxt_rdata = {4'h0, cnt_ff};
      default:       nxt_rdata = 8'h00;
    endcase
  end

  // trace memory has no reset so a retaining reset leaves it readable
  always @(posedge sys_clk)
  begin
    if (nrst & clk_en & store)
    begin
      fifo_mem[wptr_ff] <= cof_addr;
    end
  end

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      reg_rdata_ff   <= 8'h00;
      brk_req_ff     <= 1'b0;
      mcu_rst_req_ff <= 1'b0;
      armed_ff       <= 1'b0;
      begun_ff       <= 1'b0;
      prev_addr_ff   <= 16'h0000;
      rptr_ff        <= 3'h0;
      if (retain)
      begin
        // end-run results stay for the host; only arming and break enable are dropped
        ctrl_ff[`TTR_CTRL_ARM]   <= 1'b0;
        ctrl_ff[`TTR_CTRL_BREAKPOINT_REQUEST_ENABLE] <= 1'b0;
        armed_status_flag_ff                  <= 1'b0;
      end
      else
      begin
        // default begin run catching the reset vector fetch
        cax_ff  <= `TTR_RST_CAX;
        cah_ff  <= `TTR_RST_CAH;
        cal_ff  <= `TTR_RST_CAL;
        ctrl_ff <= `TTR_RST_CTRL;
        trig_ff <= `TTR_RST_TRIG;
        armed_status_flag_ff <= 1'b1;
        cnt_ff  <= 4'h0;
        wptr_ff <= 3'h0;
      end
    end
    else if (clk_en)
    begin
      reg_rdata_ff   <= reg_rd ? nxt_rdata : 8'h00;
      // no path in this unit ever requests a system reset
      mcu_rst_req_ff <= 1'b0;
      prev_addr_ff   <= core_addr;

      if (store)
      begin
        wptr_ff <= wptr_ff + 3'h1;
        if (!fifo_full)
        begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end

      if (trig_hit & begin_bit)
      begin
        begun_ff <= 1'b1;
      end

      // an unexpected read while armed must not advance the read side
      if (rd_low & ~armed)
      begin
        rptr_ff <= rptr_ff + 3'h1;
      end

      if (beg_done)
      begin
        // begin run ends only on the eighth stored word
        ctrl_ff[`TTR_CTRL_ARM] <= 1'b0;
        armed_status_flag_ff                <= 1'b0;
        begun_ff               <= 1'b0;
        brk_req_ff             <= breakpoint_request_enable_bit;
      end
      else if (end_done)
      begin
        // trigger closes the run at once
        ctrl_ff[`TTR_CTRL_ARM] <= 1'b0;
        armed_status_flag_ff                <= 1'b0;
        // break before the service routine runs
        brk_req_ff             <= breakpoint_request_enable_bit;
      end
      else if (wr_ctrl)
      begin
        ctrl_ff    <= reg_wdata;
        armed_status_flag_ff    <= reg_wdata[`TTR_CTRL_EN] & reg_wdata[`TTR_CTRL_ARM];
        brk_req_ff <= 1'b0;
        if (reg_wdata[`TTR_CTRL_ARM] & ~arm_bit)
        begin
          cnt_ff   <= 4'h0;
          wptr_ff  <= 3'h0;
          rptr_ff  <= 3'h0;
          begun_ff <= 1'b0;
        end
      end

      if (wr_trig & ~armed)
      begin
        trig_ff <= reg_wdata;
      end
      if (reg_wr & ~armed & (reg_addr == `TTR_OFS_CAX))
      begin
        cax_ff <= reg_wdata;
      end
      if (reg_wr & ~armed & (reg_addr == `TTR_OFS_CAH))
      begin
        cah_ff <= reg_wdata;
      end
      if (reg_wr & ~armed & (reg_addr == `TTR_OFS_CAL))
      begin
        cal_ff <= reg_wdata;
      end

      armed_ff <= beg_done | end_done ? 1'b0 :
                  wr_ctrl ? (reg_wdata[`TTR_CTRL_EN] & reg_wdata[`TTR_CTRL_ARM]) : armed;
    end
  end

endmodule

// [shared/ttr_defs.vh]
// constants for the trace trigger and reset priority unit
`ifndef TTR_DEFS_VH
`define TTR_DEFS_VH
`define TTR_OFS_CTRL    4'h0
`define TTR_OFS_TRIG    4'h1
`define TTR_OFS_STAT    4'h2
`define TTR_OFS_CAX     4'h3
`define TTR_OFS_CAH     4'h4
`define TTR_OFS_CAL     4'h5
`define TTR_OFS_FH      4'h6
`define TTR_OFS_FL      4'h7
`define TTR_OFS_CNT     4'h8
`define TTR_CTRL_EN     7
`define TTR_CTRL_ARM    6
`define TTR_CTRL_BREAKPOINT_REQUEST_ENABLE  5
`define TTR_TRIG_SEL    7
`define TTR_TRIG_BEGIN  6
`define TTR_STAT_ARMED_STATUS_FLAG   0
`define TTR_RST_CAX     8'h00
`define TTR_RST_CAH     8'hFF
`define TTR_RST_CAL     8'hFE
`define TTR_RST_CTRL    8'hC0
`define TTR_RST_TRIG    8'h40
`define TTR_FIFO_DEPTH  8
`define TTR_COF_STEP    16'h0002
`endif

// [tb/ttr_top_asserts.sv]
// port checker for the trace trigger unit
`timescale 1ns/1ps
module ttr_top_asserts (
  input logic       sys_clk,
  input logic       nrst,
  input logic       clk_en,
  input logic       por,
  input logic [3:0] reg_addr,
  input logic       reg_wr,
  input logic       core_fetch,
  input logic       core_top,
  input logic       brk_req_ff,
  input logic       mcu_rst_req_ff,
  input logic       armed_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  chk_no_mcu_reset: assert property (
    !mcu_rst_req_ff) else $error("mcu reset requested");
  chk_por_arms: assert property (
    $rose(nrst) && $past(por) && clk_en |-> ##[1:2] armed_ff)
    else $error("not armed after reset");
  chk_brk_disarms: assert property (
    $rose(brk_req_ff) |=> !armed_ff) else $error("armed after break");
  chk_brk_holds: assert property (
    brk_req_ff && !(reg_wr && reg_addr == 4'h0) |=> brk_req_ff) else $error("break dropped");
  chk_brk_cause: assert property (
    $rose(brk_req_ff) |-> $past(core_fetch) || $past(core_top)) else $error("break no fetch");
  chk_brk_armed: assert property (
    $rose(brk_req_ff) |-> $past(armed_ff)) else $error("break while idle");
  chk_arm_cause: assert property (
    $rose(armed_ff) |-> $past(reg_wr) || !$past(nrst, 2) || !$past(nrst, 3))
    else $error("armed without cause");
  chk_disarm_cause: assert property (
    $fell(armed_ff) |-> $past(reg_wr, 2) || $past(core_fetch, 2) || $past(core_fetch, 3))
    else $error("disarmed without cause");
endmodule
bind ttr_top ttr_top_asserts u_chk (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
  .por(por), .reg_addr(reg_addr), .reg_wr(reg_wr), .core_fetch(core_fetch),
  .core_top(core_top), .brk_req_ff(brk_req_ff), .mcu_rst_req_ff(mcu_rst_req_ff),
  .armed_ff(armed_ff));

// [tb/ttr_core_model.sv]
// core model: walks addresses, flags an interrupt at one address
`timescale 1ns/1ps
module ttr_core_model (
  input  wire        sys_clk,
  input  wire        run,
  input  wire [15:0] start,
  input  wire [15:0] irq_at,
  input  wire        halt,
  output reg  [15:0] core_addr,
  output wire        core_fetch,
  output wire        core_top,
  output wire        core_irq_pend,
  output wire [1:0]  core_cof
);
  reg go_ff = 1'b0;
  initial core_addr = 16'h0000;
  // a break stops the core one cycle after it is raised, so one more address is offered first
  always @(posedge sys_clk)
  begin
    go_ff <= run && !halt;
    core_addr <= go_ff ? core_addr + 16'h0002 : start;
  end
  assign core_fetch = go_ff;
  assign core_top = go_ff;
  assign core_irq_pend = go_ff && core_addr == irq_at;
  // every address is a change of flow, so each run cycle offers one word
  assign core_cof = {go_ff, 1'b0};
endmodule

// [tb/ttr_top_tb.sv]
// self-checking bench for the trace trigger unit
`timescale 1ns/1ps
module ttr_top_tb;
  reg         sys_clk = 0, nrst = 0, por = 1, reg_wr = 0, reg_rd = 0, run = 0;
  reg  [3:0]  reg_addr = 0;
  reg  [7:0]  reg_wdata = 0;
  reg  [15:0] start = 0, irq_at = 0;
  wire [7:0]  reg_rdata_ff;
  wire [15:0] core_addr;
  wire [1:0]  core_cof;
  wire        core_fetch, core_top, core_irq_pend, brk_req_ff, mcu_rst_req_ff, armed_ff;
  integer     bad_count = 0, compares = 0;
  always #2 sys_clk = !sys_clk;
  ttr_top dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1), .por(por), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .core_addr(core_addr), .core_fetch(core_fetch), .core_top(core_top),
    .core_irq_pend(core_irq_pend), .core_cof(core_cof), .brk_req_ff(brk_req_ff),
    .mcu_rst_req_ff(mcu_rst_req_ff), .armed_ff(armed_ff));
  ttr_core_model core (.sys_clk(sys_clk), .run(run), .start(start), .irq_at(irq_at),
    .halt(brk_req_ff), .core_addr(core_addr), .core_fetch(core_fetch), .core_top(core_top),
    .core_irq_pend(core_irq_pend), .core_cof(core_cof));
  task chk(input [39:0] what, input [7:0] exp, input [7:0] got);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH %0s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task wr(input [3:0] a, input [7:0] d);
  begin
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // one idle edge so the next call never re-drives the strobe in this step
    @(posedge sys_clk);
  end
  endtask
  task rd(input [39:0] n, input [3:0] a, input [7:0] e);
  begin
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata_ff);
    @(posedge sys_clk);
  end
  endtask
  task go(input [15:0] s, input [15:0] i);
  begin
    start <= s;
    irq_at <= i;
    run <= 1'b1;
  end
  endtask
  task t_por;
  begin
    rd("ctrl", 4'h0, 8'hC0);
    rd("trig", 4'h1, 8'h40);
    rd("cax", 4'h3, 8'h00);
    rd("cah", 4'h4, 8'hFF);
    rd("cal", 4'h5, 8'hFE);
  end
  endtask
  // interrupt pending on the reset vector fetch itself
  task t_begin;
  begin
    go(16'hFFFE, 16'hFFFE);
    repeat (30) if (armed_ff !== 1'b0) @(posedge sys_clk);
    run <= 1'b0;
    chk("brk", 8'h00, brk_req_ff);
    rd("cnt", 4'h8, 8'h08);
    rd("fl", 4'h7, 8'hFE);
  end
  endtask
  task t_end;
  begin
    wr(4'h1, 8'h00);
    wr(4'h4, 8'h12);
    wr(4'h5, 8'h34);
    wr(4'h0, 8'hE0);
    go(16'h1230, 16'h1234);
    repeat (30) if (brk_req_ff !== 1'b1) @(posedge sys_clk);
    run <= 1'b0;
    @(posedge sys_clk);
    #1 chk("brk", 8'h01, brk_req_ff);
    chk("armed", 8'h00, armed_ff);
    @(posedge sys_clk);
    rd("cnt", 4'h8, 8'h02);
  end
  endtask
  task t_retain;
  begin
    por <= 1'b0;
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    #1 chk("brk", 8'h00, brk_req_ff);
    chk("rstrq", 8'h00, mcu_rst_req_ff);
    @(posedge sys_clk);
    rd("ctrl", 4'h0, 8'h80);
    rd("trig", 4'h1, 8'h00);
    rd("cal", 4'h5, 8'h34);
    rd("cnt", 4'h8, 8'h02);
    rd("fl", 4'h7, 8'h30);
  end
  endtask
  task t_sel;
  begin
    wr(4'h1, 8'h80);
    wr(4'h0, 8'hC0);
    go(16'h1230, 16'h1234);
    repeat (12) @(posedge sys_clk);
    run <= 1'b0;
    #1 chk("armed", 8'h01, armed_ff);
    @(posedge sys_clk);
  end
  endtask
  task end_sim;
  begin
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  initial
  begin
    #4000;
    bad_count = bad_count + 1;
    end_sim;
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_por;
    t_begin;
    t_end;
    t_retain;
    t_sel;
    end_sim;
  end
endmodule
